// File: src/nni_pvc_link_status_manager.sv
// Purpose: Bidirectional PVC management engine at a network interface
// Assumes: message layer on the same clock gives one-cycle event pulses
// Notes:   Timers count seconds from one shared tick
// Behaviour
// - Poll and poll-answer procedures run at once, independently.
// - Each side keeps its own sequence state, timers and window.
// - Request full status every configured cycle count, 1-255, default 6.
// - Error threshold reached within window declares side inactive.
// - Send enquiry at each poll timer expiry, 5-30 s, default 10.
// - Verify timer supervises polls, 5-30 s, default 15.
// - Both networks use same timers, threshold and window values.
// - Defaults apply from reset; other values by provisioning only.
// - Forward full-report status to users; async optionally.
// - Active bit sent each way ignores bit received the other way.
// - After a segment change answer next poll with full status; in async report mode an async report is sent instead.
// - Channel down at start until window count of valid cycles.
// - Optionally up after a valid first cycle; else full count.
// - Active only if segments, links and interfaces all operate.
// - Bidirectional remote user must itself report active.
// - Any failed criterion forces active bit zero.
// - Only a terminating network originates active one.
// - Intermediate network passes bit unchanged or forces zero.
// - Peer is both source and sink of enquiries and of replies.
// - Reports toward users include every traversed network.
// - Enquiries and replies exchanged continuously on every poll.
`timescale 1ns/1ps
`include "nplsm_consts.svh"
module nni_pvc_link_status_manager
  import nplsm_pkg::*;
#(
  parameter int NUM_PVC     = 4,
  parameter int TICK_CYCLES = `NPLSM_TICK_CYC
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    enq_send,
  output logic                    enq_full,
  input  wire logic               reply_rx,
  input  wire logic               reply_seq_ok,
  input  wire logic               poll_rx,
  input  wire logic               poll_seq_ok,
  input  wire logic               poll_full_req,
  output logic                    reply_send,
  output logic                    reply_full,
  output logic                    async_send,
  input  wire logic               seg_change,
  input  wire logic               rpt_valid,
  input  wire logic               rpt_full,
  input  wire logic [NUM_PVC-1:0] rpt_sel,
  input  wire logic [NUM_PVC-1:0] rpt_active,
  input  wire logic [NUM_PVC-1:0] seg_cfg,
  input  wire logic [NUM_PVC-1:0] seg_oper,
  input  wire logic               uni_ok,
  input  wire logic [NUM_PVC-1:0] terminating,
  input  wire logic [NUM_PVC-1:0] remote_bidir,
  input  wire logic [NUM_PVC-1:0] near_active,
  output logic [NUM_PVC-1:0]      user_active,
  output logic [NUM_PVC-1:0]      peer_active,
  output logic                    chan_op
);
  if (NUM_PVC < 1 || NUM_PVC > 32) begin : g_chk
    $error("NUM_PVC must be 1 to 32");
  end

  logic [3:0]          ctrl_reg;
  logic [25:0]         param_reg;
  logic                par_ok;
  logic                en;
  logic                tick;
  logic [4:0]          poll_sec_reg;
  logic [4:0]          ver_sec_reg;
  logic                poll_exp;
  logic                ver_exp;
  nplsm_poll_t         poll_st_reg;
  logic [7:0]          full_cyc_reg;
  logic                poll_ev;
  logic                poll_ev_ok;
  logic                ans_ev;
  logic                poll_op;
  logic                ans_op;
  logic [3:0]          poll_err;
  logic [3:0]          ans_err;
  logic                pend_reg;
  logic [NUM_PVC-1:0]  rx_active_reg;
  logic [NUM_PVC-1:0]  crit_ok;
  logic [NUM_PVC-1:0]  bidir_ok;

  ////////////////////////////////////////////////////////////////////////
  // Register port
  ////////////////////////////////////////////////////////////////////////
  assign en = ctrl_reg[`NPLSM_CTRL_EN];
  // Whole write refused if any field is outside its range
  assign par_ok =
    (reg_wdata[`NPLSM_F_FULL] >= `NPLSM_FULL_MIN) &&
    (reg_wdata[`NPLSM_F_THR] >= `NPLSM_CNT_MIN) &&
    (reg_wdata[`NPLSM_F_THR] <= `NPLSM_CNT_MAX) &&
    (reg_wdata[`NPLSM_F_WIN] >= `NPLSM_CNT_MIN) &&
    (reg_wdata[`NPLSM_F_WIN] <= `NPLSM_CNT_MAX) &&
    (reg_wdata[`NPLSM_F_POLLT] >= `NPLSM_T_MIN) &&
    (reg_wdata[`NPLSM_F_POLLT] <= `NPLSM_T_MAX) &&
    (reg_wdata[`NPLSM_F_VERT] >= `NPLSM_T_MIN) &&
    (reg_wdata[`NPLSM_F_VERT] <= `NPLSM_T_MAX);

  // Control and parameter writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= `NPLSM_CTRL_RST;
      param_reg <= {`NPLSM_VERT_DEF, `NPLSM_POLLT_DEF, `NPLSM_CNT_DEF_WIN,
                    `NPLSM_CNT_DEF_THR, `NPLSM_FULL_DEF};
    end else if (reg_wr) begin
      if (reg_addr == `NPLSM_ADDR_CTRL) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      // Provisioning only while stopped
      if (reg_addr == `NPLSM_ADDR_PARAM && par_ok && !en) begin
        param_reg <= reg_wdata[25:0];
      end
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `NPLSM_ADDR_CTRL:   reg_rdata <= {28'h0, ctrl_reg};
        `NPLSM_ADDR_PARAM:  reg_rdata <= {6'h0, param_reg};
        `NPLSM_ADDR_STATUS: reg_rdata <= {17'h0, poll_st_reg, ans_err,
                              poll_err, pend_reg, chan_op, ans_op, poll_op};
        `NPLSM_ADDR_UACT:   reg_rdata <= 32'(user_active);
        `NPLSM_ADDR_PACT:   reg_rdata <= 32'(peer_active);
        default:            reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Seconds timers
  ////////////////////////////////////////////////////////////////////////
  nplsm_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .restart(!en),
    .tick   (tick)
  );

  assign poll_exp = en && tick && (poll_sec_reg == 5'h01);
  assign ver_exp  = en && tick && (ver_sec_reg == 5'h01);

  // Poll interval timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_sec_reg <= `NPLSM_POLLT_DEF;
    end else if (!en || poll_exp) begin
      poll_sec_reg <= param_reg[`NPLSM_F_POLLT];
    end else if (tick) begin
      poll_sec_reg <= poll_sec_reg - 5'h01;
    end
  end

  // Poll verify timer, restarted by each poll
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ver_sec_reg <= `NPLSM_VERT_DEF;
    end else if (!en || ver_exp || poll_rx) begin
      ver_sec_reg <= param_reg[`NPLSM_F_VERT];
    end else if (tick) begin
      ver_sec_reg <= ver_sec_reg - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Polling side
  ////////////////////////////////////////////////////////////////////////
  // Outstanding enquiry tracking
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_st_reg <= PS_OFF;
    end else if (!en) begin
      poll_st_reg <= PS_OFF;
    end else begin
      unique case (poll_st_reg)
        PS_OFF:  poll_st_reg <= PS_IDLE;
        PS_IDLE: if (poll_exp) poll_st_reg <= PS_WAIT;
        PS_WAIT: if (reply_rx) poll_st_reg <= PS_IDLE;
        default: poll_st_reg <= PS_OFF;
      endcase
    end
  end

  // Reply or missed reply closes a cycle
  assign poll_ev    = (poll_st_reg == PS_WAIT) && (reply_rx || poll_exp);
  assign poll_ev_ok = reply_rx && reply_seq_ok;

  // Enquiry on expiry, full request every N cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enq_send     <= 1'b0;
      enq_full     <= 1'b0;
      full_cyc_reg <= 8'h00;
    end else if (!en) begin
      enq_send     <= 1'b0;
      enq_full     <= 1'b0;
      full_cyc_reg <= 8'h00;
    end else begin
      enq_send <= poll_exp;
      if (poll_exp) begin
        if (full_cyc_reg == param_reg[`NPLSM_F_FULL] - 8'h01) begin
          full_cyc_reg <= 8'h00;
          enq_full     <= 1'b1;
        end else begin
          full_cyc_reg <= full_cyc_reg + 8'h01;
          enq_full     <= 1'b0;
        end
      end
    end
  end

  nplsm_err_window u_poll_win (
    .clk      (clk),
    .arst_n   (arst_n),
    .clear    (!en),
    .ev_valid (poll_ev),
    .ev_ok    (poll_ev_ok),
    .thr      (param_reg[`NPLSM_F_THR]),
    .win      (param_reg[`NPLSM_F_WIN]),
    .alt_start(ctrl_reg[`NPLSM_CTRL_ALT]),
    .oper     (poll_op),
    .err_cnt  (poll_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // Answering side
  ////////////////////////////////////////////////////////////////////////
  // Poll or verify expiry is one monitored event
  assign ans_ev = en && (poll_rx || ver_exp);

  nplsm_err_window u_ans_win (
    .clk      (clk),
    .arst_n   (arst_n),
    .clear    (!en),
    .ev_valid (ans_ev),
    .ev_ok    (poll_rx && poll_seq_ok),
    .thr      (param_reg[`NPLSM_F_THR]),
    .win      (param_reg[`NPLSM_F_WIN]),
    .alt_start(ctrl_reg[`NPLSM_CTRL_ALT]),
    .oper     (ans_op),
    .err_cnt  (ans_err)
  );

  // Pending full report after segment change, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
    end else if (seg_change && !ctrl_reg[`NPLSM_CTRL_ARPT]) begin
      pend_reg <= 1'b1;
    end else if (en && poll_rx) begin
      pend_reg <= 1'b0;
    end
  end

  // Reply to every poll
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_send <= 1'b0;
      reply_full <= 1'b0;
      async_send <= 1'b0;
    end else begin
      reply_send <= en && poll_rx;
      reply_full <= en && poll_rx && (poll_full_req || pend_reg);
      async_send <= en && seg_change && ctrl_reg[`NPLSM_CTRL_ARPT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Active bit handling
  ////////////////////////////////////////////////////////////////////////
  // Channel needs both procedure sides up
  assign chan_op = poll_op && ans_op;

  // Learned peer status; absent from full report means inactive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_active_reg <= '0;
    end else if (rpt_valid && rpt_full) begin
      rx_active_reg <= rpt_active & rpt_sel;
    end else if (rpt_valid && ctrl_reg[`NPLSM_CTRL_AFWD]) begin
      rx_active_reg <= (rx_active_reg & ~rpt_sel) |
                       (rpt_active & rpt_sel);
    end
  end

  // Local criteria
  assign crit_ok  = seg_cfg & seg_oper & {NUM_PVC{uni_ok && chan_op}};
  assign bidir_ok = ~remote_bidir | near_active;

  // Outputs per direction, each from its own source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      user_active <= '0;
      peer_active <= '0;
    end else begin
      // Pass peer bit or force zero
      user_active <= crit_ok & rx_active_reg;
      // Originate when terminating, else pass
      peer_active <= crit_ok & ((terminating & bidir_ok) |
                                (~terminating & near_active));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_enq_at_expiry: assert property (
    enq_send |-> poll_sec_reg == param_reg[`NPLSM_F_POLLT] && en)
    else $error("enquiry without timer reload");
  a_full_cycle: assert property (
    enq_send |-> (enq_full == (full_cyc_reg == 8'h00)))
    else $error("full request off its cycle");
  a_crit_gate: assert property (
    ((user_active | peer_active) & ~$past(crit_ok)) == '0)
    else $error("active without criteria");
  a_bidir_remote: assert property (
    (peer_active & $past(terminating) & ~$past(bidir_ok)) == '0)
    else $error("active despite remote user inactive");
  a_fail_zero: assert property (
    !chan_op |=> user_active == '0 && peer_active == '0)
    else $error("channel down but active sent");
  a_pass_or_zero: assert property (
    (user_active & ~$past(rx_active_reg)) == '0)
    else $error("user bit not from peer");
  a_start_down: assert property (
    !en |=> !chan_op [*2])
    else $error("channel up while stopped");
  a_pend_set: assert property (
    seg_change && !ctrl_reg[`NPLSM_CTRL_ARPT] |=> pend_reg)
    else $error("segment change lost");
  a_reply_poll: assert property (
    en && poll_rx && pend_reg |=> reply_send && reply_full)
    else $error("poll not answered with full report");

  c_full_enq:  cover property (enq_send && enq_full);
  c_chan_up:   cover property ($rose(chan_op));
  c_user_act:  cover property (user_active != '0);
  c_full_rply: cover property (reply_send && reply_full);
endmodule : nni_pvc_link_status_manager

// File: src/nplsm_consts.svh
// Purpose: Named offsets, fields, defaults and timing for the PVC manager
// Assumes: 200 MHz system clock
// Notes:   Definitions only
`ifndef NPLSM_CONSTS_SVH
`define NPLSM_CONSTS_SVH
// Register offsets
`define NPLSM_ADDR_CTRL   8'h00
`define NPLSM_ADDR_PARAM  8'h04
`define NPLSM_ADDR_STATUS 8'h08
`define NPLSM_ADDR_UACT   8'h0c
`define NPLSM_ADDR_PACT   8'h10
// Control bits
`define NPLSM_CTRL_EN     0
`define NPLSM_CTRL_ALT    1
`define NPLSM_CTRL_AFWD   2
`define NPLSM_CTRL_ARPT   3
`define NPLSM_CTRL_RST    4'h0
// Parameter fields, ranges and defaults
`define NPLSM_F_FULL      7:0
`define NPLSM_F_THR       11:8
`define NPLSM_F_WIN       15:12
`define NPLSM_F_POLLT     20:16
`define NPLSM_F_VERT      25:21
`define NPLSM_FULL_DEF    8'h06
`define NPLSM_FULL_MIN    8'h01
`define NPLSM_CNT_DEF_THR 4'h3
`define NPLSM_CNT_DEF_WIN 4'h4
`define NPLSM_CNT_MIN     4'h1
`define NPLSM_CNT_MAX     4'ha
`define NPLSM_POLLT_DEF   5'h0a
`define NPLSM_VERT_DEF    5'h0f
`define NPLSM_T_MIN       5'h05
`define NPLSM_T_MAX       5'h1e
// One-second tick
`define NPLSM_TICK_NS     1000000000
`define NPLSM_CLK_NS      5
`define NPLSM_TICK_CYC    (`NPLSM_TICK_NS / `NPLSM_CLK_NS)
`define NPLSM_HIST_W      10
`endif

// File: src/nplsm_err_window.sv
// Purpose: Error window and operational state for one procedure side
// Assumes: events are one-cycle pulses
// Notes:   Keeps the last ten events, counts errors in the window
`timescale 1ns/1ps
`include "nplsm_consts.svh"
module nplsm_err_window (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       ev_valid,
  input  wire logic       ev_ok,
  input  wire logic [3:0] thr,
  input  wire logic [3:0] win,
  input  wire logic       alt_start,
  output logic            oper,
  output logic [3:0]      err_cnt
);
  logic [`NPLSM_HIST_W-1:0] hist_reg;
  logic [`NPLSM_HIST_W-1:0] hist_next;
  logic [3:0]               run_reg;
  logic [3:0]               run_next;
  logic [3:0]               err_next;
  logic                     first_reg;

  // Errors among the newest win events
  function automatic logic [3:0] errs(input logic [`NPLSM_HIST_W-1:0] h,
                                      input logic [3:0] w);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < `NPLSM_HIST_W; i++) begin
      if (h[i] && (i < int'(w))) c = c + 4'h1;
    end
    return c;
  endfunction : errs

  assign hist_next = {hist_reg[`NPLSM_HIST_W-2:0], ~ev_ok};
  assign err_next  = errs(hist_next, win);
  assign run_next  = !ev_ok ? 4'h0 :
                     (run_reg == `NPLSM_CNT_MAX) ? run_reg : run_reg + 4'h1;
  assign err_cnt   = errs(hist_reg, win);

  // History and valid run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hist_reg  <= '0;
      run_reg   <= 4'h0;
      first_reg <= 1'b1;
    end else if (clear) begin
      hist_reg  <= '0;
      run_reg   <= 4'h0;
      first_reg <= 1'b1;
    end else if (ev_valid) begin
      hist_reg  <= hist_next;
      run_reg   <= run_next;
      first_reg <= 1'b0;
    end
  end

  // Operational decision
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oper <= 1'b0;
    end else if (clear) begin
      oper <= 1'b0;
    end else if (ev_valid) begin
      if (first_reg && alt_start && ev_ok) begin
        oper <= 1'b1;
      end else if (err_next >= thr) begin
        oper <= 1'b0;
      end else if (run_next >= win) begin
        oper <= 1'b1;
      end
    end
  end
endmodule : nplsm_err_window

// File: src/nplsm_pkg.sv
// Purpose: Types shared by the PVC manager
// Assumes: nothing
// Notes:   One-hot codes for the polling side
package nplsm_pkg;
  typedef enum logic [2:0] {
    PS_OFF  = 3'b001,
    PS_IDLE = 3'b010,
    PS_WAIT = 3'b100
  } nplsm_poll_t;
endpackage : nplsm_pkg

// File: src/nplsm_tick.sv
// Purpose: One-cycle pulse once per second
// Assumes: single clock
// Notes:   Restarts its count while restart is high
`timescale 1ns/1ps
`include "nplsm_consts.svh"
module nplsm_tick #(
  parameter int TICK_CYCLES = `NPLSM_TICK_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic restart,
  output logic      tick
);
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES too small");
  end
  logic [31:0] cnt_reg;
  // Divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (restart) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule : nplsm_tick

// File: verif/nplsm_peer.sv
// Purpose: Peer network engine facing the block
// Assumes: same clock as the block, one-cycle pulses
// Notes:   Polls on its own timer and answers enquiries
`timescale 1ns/1ps
module nplsm_peer #(
  parameter int POLL_CYC = 100,
  parameter int FULL_N   = 3
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic answer,
  input  wire logic slow,
  input  wire logic enq_send,
  output logic      reply_rx,
  output logic      reply_seq_ok,
  output logic      poll_rx,
  output logic      poll_seq_ok,
  output logic      poll_full_req
);
  int poll_cnt;
  int poll_num;
  int dly;
  //////////////////////////////////////////////////////////////////////////
  // Own poll timer; qualifiers toggle when not valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_cnt      <= 0;
      poll_num      <= 0;
      poll_rx       <= 1'b0;
      poll_seq_ok   <= 1'b0;
      poll_full_req <= 1'b0;
    end else begin
      poll_rx       <= 1'b0;
      poll_seq_ok   <= ~poll_seq_ok;
      poll_full_req <= ~poll_full_req;
      poll_cnt      <= poll_cnt + 1;
      if (poll_cnt == POLL_CYC - 1) begin
        poll_cnt      <= 0;
        poll_num      <= poll_num + 1;
        poll_rx       <= 1'b1;
        poll_seq_ok   <= 1'b1;
        poll_full_req <= ((poll_num + 1) % FULL_N) == 0;
      end
    end
  end
  // Answer each enquiry promptly or slowly, or not at all
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly          <= 0;
      reply_rx     <= 1'b0;
      reply_seq_ok <= 1'b0;
    end else begin
      reply_rx     <= 1'b0;
      reply_seq_ok <= ~reply_seq_ok;
      if (enq_send && answer) begin
        dly <= slow ? 40 : 2;
      end else if (dly != 0) begin
        dly <= dly - 1;
      end
      if (dly == 1) begin
        reply_rx     <= 1'b1;
        reply_seq_ok <= 1'b1;
      end
    end
  end
endmodule : nplsm_peer

// File: verif/tb.sv
// Purpose: Self-checking bench for the PVC manager
// Assumes: ten-cycle seconds tick
// Notes:   Expected results queued by drivers, checked by monitors
`timescale 1ns/1ps
`include "nplsm_consts.svh"
module tb;
  import nplsm_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m;} nplsm_exp_t;
  logic       clk, arst_n, reg_wr, reg_rd, rd_seen, seg_change, uni_ok;
  logic       rpt_valid, rpt_full, answer, slow, pend, en_m;
  logic       arpt_m, as_exp;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic       enq_send, enq_full, reply_rx, reply_seq_ok, poll_rx;
  logic       poll_seq_ok, poll_full_req, reply_send, reply_full;
  logic       async_send, chan_op;
  logic [3:0] rpt_sel, rpt_active, seg_cfg, seg_oper, terminating;
  logic [3:0] remote_bidir, near_active, user_active, peer_active;
  logic [3:0] c, o, t, b, na, ra, s, lrn;
  nplsm_exp_t rd_q[$];
  logic       rp_q[$];
  nplsm_exp_t e;
  int         err_count, samples_checked, cycles, enq_k, full_n;
  //////////////////////////////////////////////////////////////////////////
  nni_pvc_link_status_manager #(.NUM_PVC(4), .TICK_CYCLES(10))
    i_nni_pvc_link_status_manager (.*);
  nplsm_peer #(.POLL_CYC(100), .FULL_N(3)) i_nplsm_peer (.*);
  // Clock, cycle limit
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rd_seen <= reg_rd;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m);
    rd_q.push_back('{v: v, m: m});
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd
  function automatic logic [31:0] pk(input logic [7:0] f,
    input logic [3:0] th, input logic [3:0] w, input logic [4:0] p,
    input logic [4:0] vt);
    return {6'h00, vt, p, w, th, f};
  endfunction : pk
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  // Note expected reply kind whenever a poll is taken
  always @(posedge clk) begin
    if (poll_rx && en_m) begin
      rp_q.push_back(poll_full_req | pend);
    end
    as_exp <= seg_change && arpt_m;
    if (seg_change && !arpt_m) begin
      pend = 1'b1;
    end else if (poll_rx && en_m) begin
      pend = 1'b0;
    end
  end
  // Compare results where they have settled
  always @(negedge clk) begin
    if (rd_seen) begin
      e = rd_q.pop_front();
      cmp(reg_rdata & e.m, e.v);
    end
    if (reply_send) begin
      cmp({31'h0, rp_q.size() > 0}, 32'h1);
      if (rp_q.size() > 0) begin
        cmp({31'h0, reply_full}, {31'h0, rp_q.pop_front()});
      end
    end
    if (async_send || as_exp) begin
      cmp({31'h0, async_send}, {31'h0, as_exp});
    end
    if (enq_send) begin
      enq_k++;
      cmp({31'h0, enq_full}, {31'h0, (enq_k % full_n) == 0});
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hbbf8));
    {arst_n, reg_wr, reg_rd, seg_change, rpt_valid, rpt_full} = '0;
    {reg_addr, reg_wdata, rpt_sel, rpt_active, seg_cfg} = '0;
    {seg_oper, terminating, remote_bidir, near_active} = '0;
    {uni_ok, answer, slow, pend, en_m, lrn, arpt_m} = '0;
    {err_count, samples_checked, cycles, enq_k} = '0;
    full_n = 2;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unmapped place, one accepted and two refused writes
    rd(`NPLSM_ADDR_PARAM, pk(`NPLSM_FULL_DEF, `NPLSM_CNT_DEF_THR,
       `NPLSM_CNT_DEF_WIN, `NPLSM_POLLT_DEF, `NPLSM_VERT_DEF), '1);
    rd(`NPLSM_ADDR_STATUS, 32'h1000, 32'h7007);
    rd(8'h20, 32'h0, '1);
    wr(`NPLSM_ADDR_PARAM, pk(8'h02, 4'h3, 4'h4, 5'h0a, 5'h0f));
    wr(`NPLSM_ADDR_PARAM, pk(8'h02, 4'h0, 4'h4, 5'h0a, 5'h0f));
    wr(`NPLSM_ADDR_PARAM, pk(8'h02, 4'h3, 4'h4, 5'h04, 5'h0f));
    rd(`NPLSM_ADDR_PARAM, pk(8'h02, 4'h3, 4'h4, 5'h0a, 5'h0f),
       '1);
    // Enable with a slow peer; channel stays down early
    answer <= 1'b1;
    slow   <= 1'b1;
    uni_ok <= 1'b1;
    wr(`NPLSM_ADDR_CTRL, 32'h1);
    en_m = 1'b1;
    repeat (250) @(posedge clk);
    rd(`NPLSM_ADDR_STATUS, 32'h0, 32'h4);
    for (int i = 0; i < 800 && chan_op !== 1'b1; i++) @(posedge clk);
    rd(`NPLSM_ADDR_STATUS, 32'h7, 32'h7);
    @(posedge clk);
    seg_change <= 1'b1;
    @(posedge clk);
    seg_change <= 1'b0;
    slow       <= 1'b0;
    // Async report mode and async forwarding on, second segment change
    wr(`NPLSM_ADDR_CTRL, 32'hd);
    arpt_m = 1'b1;
    @(posedge clk);
    seg_change <= 1'b1;
    @(posedge clk);
    seg_change <= 1'b0;
    // Active bit combinations; last report is async and forwarded
    for (int i = 0; i < 6; i++) begin
      {c, o, t, b, na, ra, s} = 28'($urandom);
      lrn = (i < 5) ? ra & s : (lrn & ~s) | (ra & s);
      @(posedge clk);
      {seg_cfg, seg_oper, terminating, remote_bidir} <= {c, o, t, b};
      {near_active, rpt_active, rpt_sel} <= {na, ra, s};
      uni_ok    <= i != 2;
      rpt_valid <= 1'b1;
      rpt_full  <= i < 5;
      @(posedge clk);
      rpt_valid <= 1'b0;
      if (i == 2) {c, o} = '0;
      repeat (3) @(posedge clk);
      rd(`NPLSM_ADDR_UACT, {28'h0, c & o & lrn}, '1);
      rd(`NPLSM_ADDR_PACT, {28'h0, c & o & (t & (~b | na) | ~t & na)},
         '1);
    end
    // Peer stops answering: polling side falls, answering side stays
    answer <= 1'b0;
    for (int i = 0; i < 700 && chan_op !== 1'b0; i++) @(posedge clk);
    rd(`NPLSM_ADDR_STATUS, 32'h2, 32'h7);
    rd(`NPLSM_ADDR_UACT, 32'h0, '1);
    // Restart with the quick start-up option: up after one good cycle
    answer <= 1'b1;
    wr(`NPLSM_ADDR_CTRL, 32'h0);
    enq_k  = 0;
    arpt_m = 1'b0;
    wr(`NPLSM_ADDR_CTRL, 32'h3);
    for (int i = 0; i < 200 && chan_op !== 1'b1; i++) @(posedge clk);
    rd(`NPLSM_ADDR_STATUS, 32'h7, 32'h7);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb
